// ===== sim/timer_capture_compare_gated_modes_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module timer_capture_compare_gated_modes_tb_top;
    import tmccg_pkg::*;
    logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, timer_in, timer_out, timer_out_en, timer_irq;
    logic level, noise_en, noise_bit, irq_q, o1;
    logic [31:0] rnd = 32'h60a2b611;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic [7:0] last_rd, cap;
    int n_mismatch = 0, compares = 0, n_irq = 0, gap = 0, last_irq = 0, cyc_n = 0;
    tmccg_timer i_tmccg_timer (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_in(timer_in),
        .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_irq(timer_irq));
    tmccg_pin_model i_tmccg_pin_model (.sys_clk(sys_clk), .noise_en(noise_en),
        .noise_bit(noise_bit), .level(level), .timer_in(timer_in));
    // ==========================================
    // Clock, random pin noise, helpers
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout;
        n_mismatch++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        results();
    endtask
    task automatic wb_xfer(input logic we, input logic [2:0] idx, input logic [7:0] d, input logic [8:0] x);
        int n;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, 24'h0, d};
        if (!we) exp_q.push_back(x);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) timeout();
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        wb_xfer(1'b1, idx, d, 9'h000);
    endtask
    task automatic rd(input logic [2:0] idx, input logic [8:0] x);
        wb_xfer(1'b0, idx, 8'h00, x);
    endtask
    task automatic wait_irq(input int lim);
        int n0;
        int k;
        n0 = n_irq;
        k = 0;
        while (n_irq == n0 && k < lim) begin
            @(posedge sys_clk);
            k++;
        end
        if (n_irq == n0) timeout();
    endtask
    task automatic quiet(input int n);
        int n0;
        n0 = n_irq;
        repeat (n) @(posedge sys_clk);
        check(16'(n_irq - n0), 16'h0000);
    endtask
    task automatic cap_once;
        wait_irq(80);
        check(16'(gap), 16'h0040);
        level <= 1'b0;
        repeat (3) @(posedge sys_clk);
        level <= 1'b1;
        wait_irq(20);
        level <= 1'b0;
    endtask
    // ==========================================
    // Read watcher and event monitor
    always @(posedge sys_clk) begin
        rnd = xs(rnd);
        noise_bit <= rnd[0];
        cyc_n++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            last_rd = wb_dat_o[7:0];
            e = exp_q.pop_front();
            if (e[8]) check({8'h00, wb_dat_o[7:0]}, {8'h00, e[7:0]});
        end
        if (timer_irq === 1'b1) begin
            if (irq_q === 1'b1) check(16'h0001, 16'h0000);
            n_irq++;
            gap = cyc_n - last_irq;
            last_irq = cyc_n;
        end
        irq_q = timer_irq;
    end
    // ==========================================
    // Main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'h1;
        {level, noise_en, rst_n} = 3'b000;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wr(3'h6, 8'h5a);
        rd(3'h6, 9'h100);
        rd(ADDR_CTL, 9'h100);
        rd(ADDR_RLD_HI, 9'h1ff);
        rd(ADDR_CAP_LO, 9'h100);
        rd(ADDR_CNT_LO, 9'h101);
        // Compare: start below all-ones, match only after the wrap
        wr(ADDR_CTL, 8'h05);
        wr(ADDR_CNT_HI, 8'hff);
        wr(ADDR_CNT_LO, 8'hfc);
        wr(ADDR_RLD_HI, 8'h00);
        wr(ADDR_RLD_LO, 8'h04);
        rd(ADDR_RLD_HI, 9'h100);
        rd(ADDR_RLD_LO, 9'h104);
        noise_en <= 1'b1;
        wr(ADDR_CTL, 8'h8d);
        wait_irq(40);
        repeat (2) @(posedge sys_clk);
        check({14'h0, timer_out, timer_out_en}, 16'h0003);
        quiet(100);
        noise_en <= 1'b0;
        wr(ADDR_CTL, 8'h0d);
        check({14'h0, timer_out, timer_out_en}, 16'h0000);
        // Gated: no counting while the input is inactive
        wr(ADDR_CTL, 8'h46);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_CNT_LO, 8'h01);
        wr(ADDR_RLD_HI, 8'h01);
        wr(ADDR_RLD_LO, 8'h00);
        wr(ADDR_CTL, 8'hc6);
        quiet(30);
        rd(ADDR_CNT_HI, 9'h100);
        rd(ADDR_CNT_LO, 9'h101);
        level <= 1'b1;
        repeat (20) @(posedge sys_clk);
        level <= 1'b0;
        wait_irq(10);
        quiet(40);
        // Gated reloads: first pass from 3, later passes from one
        wr(ADDR_CTL, 8'h4e);
        wr(ADDR_CNT_LO, 8'h03);
        wr(ADDR_RLD_HI, 8'h00);
        wr(ADDR_RLD_LO, 8'h05);
        wr(ADDR_CTL, 8'hce);
        level <= 1'b1;
        wait_irq(20);
        repeat (2) @(posedge sys_clk);
        o1 = timer_out;
        wait_irq(20);
        check(16'(gap), 16'h000a);
        repeat (2) @(posedge sys_clk);
        check({15'h0, timer_out}, {15'h0, ~o1});
        level <= 1'b0;
        // Capture/compare: idle until first edge, then equal captures
        wr(ADDR_CTL, 8'h47);
        wr(ADDR_CNT_LO, 8'h01);
        wr(ADDR_RLD_LO, 8'h40);
        wr(ADDR_CTL, 8'hc7);
        quiet(30);
        level <= 1'b1;
        quiet(10);
        wait_irq(80);
        cap_once();
        rd(ADDR_CAP_LO, 9'h000);
        cap = last_rd;
        cap_once();
        rd(ADDR_CAP_HI, 9'h100);
        rd(ADDR_CAP_LO, {1'b1, cap});
        // Capture on falling edge, counter keeps running
        wr(ADDR_CTL, 8'h04);
        wr(ADDR_CNT_LO, 8'h01);
        wr(ADDR_RLD_HI, 8'hff);
        wr(ADDR_RLD_LO, 8'hff);
        wr(ADDR_CAP_HI, 8'h00);
        wr(ADDR_CAP_LO, 8'h00);
        level <= 1'b1;
        wr(ADDR_CTL, 8'h84);
        quiet(20);
        level <= 1'b0;
        wait_irq(20);
        level <= 1'b1;
        quiet(30);
        rd(ADDR_CAP_LO, 9'h000);
        cap = last_rd;
        check({15'h0, cap == 8'h00}, 16'h0000);
        wr(ADDR_CTL, 8'h04);
        rd(ADDR_CNT_LO, 9'h000);
        check({15'h0, last_rd > cap}, 16'h0001);
        // Capture reaching reload: interrupt, pair stays zero, count runs on
        wr(ADDR_CNT_LO, 8'h01);
        wr(ADDR_RLD_HI, 8'h00);
        wr(ADDR_RLD_LO, 8'h10);
        wr(ADDR_CAP_LO, 8'h00);
        wr(ADDR_CTL, 8'h84);
        wait_irq(40);
        rd(ADDR_CAP_LO, 9'h100);
        wr(ADDR_CTL, 8'h04);
        rd(ADDR_CNT_LO, 9'h000);
        check({15'h0, last_rd > 8'h10}, 16'h0001);
        // Fallback mode: reload to one toggles the pin
        wr(ADDR_CTL, 8'h08);
        wr(ADDR_CNT_LO, 8'h01);
        wr(ADDR_RLD_LO, 8'h08);
        wr(ADDR_CTL, 8'h88);
        wait_irq(40);
        o1 = timer_out;
        wait_irq(40);
        check(16'(gap), 16'h0010);
        check({15'h0, timer_out}, {15'h0, ~o1});
        results();
    end
endmodule
`default_nettype wire

// ===== sim/tmccg_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Timer input pin, driven from the far side
module tmccg_pin_model (
    input wire logic sys_clk,
    input wire logic noise_en,
    input wire logic noise_bit,
    input wire logic level,
    output logic timer_in
);
    // Pin moves just after the edge, like a real port
    always @(posedge sys_clk) begin
        timer_in <= noise_en ? noise_bit : level;
    end
endmodule
`default_nettype wire

// ===== verilog/tmccg_pkg.sv
package tmccg_pkg;
    localparam logic [2:0] ADDR_CNT_HI = 3'h0;
    localparam logic [2:0] ADDR_CNT_LO = 3'h1;
    localparam logic [2:0] ADDR_RLD_HI = 3'h2;
    localparam logic [2:0] ADDR_RLD_LO = 3'h3;
    localparam logic [2:0] ADDR_CAP_HI = 3'h4;
    localparam logic [2:0] ADDR_CAP_LO = 3'h5;
    localparam logic [2:0] ADDR_CTL = 3'h7;
    localparam int ADDR_LSB = 2;
    localparam int CTL_RUN = 7;
    localparam int CTL_POL = 6;
    localparam int CTL_PRES_LO = 3;
    localparam int CTL_OUTEN = 3;
    localparam logic [15:0] CNT_RESET = 16'h0001;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] RLD_RESET = 16'hffff;
    localparam logic [15:0] CAP_RESET = 16'h0000;
    localparam logic [7:0] CTL_RESET = 8'h00;
    typedef enum logic [2:0] {
        MODE_CAPTURE = 3'h4,
        MODE_COMPARE = 3'h5,
        MODE_GATED = 3'h6,
        MODE_CAPCMP = 3'h7,
        MODE_OTHER = 3'h0
    } tmccg_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } tmccg_state_t;
endpackage

// ===== verilog/tmccg_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tmccg_timer #(
    parameter int PRES_BITS = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_in,
    output logic timer_out,
    output logic timer_out_en,
    output logic timer_irq
);
    import tmccg_pkg::*;

    if (PRES_BITS != 3) begin : g_pres_check
        $error("PRES_BITS must be 3");
    end

    // ==========================================================
    // Bus decode
    // ==========================================================
    logic [7:0] ctl_q, ctl_d;
    logic [15:0] cnt_q, cnt_d, rld_q, cap_q, cap_d;
    logic [7:0] rld_hold_q, lo_hold_q;
    logic [6:0] pres_q;
    logic [1:0] sync_q;
    logic in_prev_q;
    tmccg_state_t st_q, st_d;
    logic out_q, out_d, irq_q, irq_d, ack_q;
    logic [31:0] rdat_q;

    wire logic acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic [2:0] idx = wb_adr_i[4:ADDR_LSB];
    wire logic wr = acc & wb_we_i & wb_sel_i[0];
    wire logic rd = acc & ~wb_we_i;
    wire logic run = ctl_q[CTL_RUN];
    wire logic pol = ctl_q[CTL_POL];
    wire logic [2:0] pres_sel = ctl_q[5:CTL_PRES_LO];
    wire tmccg_mode_t mode = tmccg_mode_t'(ctl_q[2:0]);
    wire logic [7:0] wbyte = wb_dat_i[7:0];

    // ==========================================================
    // Prescaler and input sampling
    // ==========================================================
    wire logic [6:0] pres_max = 7'((8'h01 << pres_sel) - 8'h01);
    wire logic tick = run & (pres_q >= pres_max);
    wire logic in_s = sync_q[1];
    wire logic in_act = in_s ~^ pol;
    wire logic sel_edge = (in_s != in_prev_q) & in_act;
    wire logic gate_off = (in_s != in_prev_q) & ~in_act;
    wire logic at_rld = (cnt_q == rld_q);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pres_q <= 7'h00;
            sync_q <= 2'b00;
            in_prev_q <= 1'b0;
        end else begin
            pres_q <= (!run || tick) ? 7'h00 : 7'(pres_q + 7'h01);
            sync_q <= {sync_q[0], timer_in};
            in_prev_q <= sync_q[1];
        end
    end

    // ==========================================================
    // Counter engine
    // ==========================================================
    always_comb begin
        cnt_d = cnt_q;
        cap_d = cap_q;
        st_d = st_q;
        out_d = out_q;
        irq_d = 1'b0;
        if (!run) begin
            st_d = ST_IDLE;
            out_d = pol;
        end else begin
            case (mode)
                MODE_CAPTURE: begin
                    if (sel_edge) begin
                        cap_d = cnt_q;
                        irq_d = 1'b1;
                    end
                    if (tick) begin
                        if (at_rld) begin
                            irq_d = 1'b1;
                        end
                        cnt_d = 16'(cnt_q + 16'h0001);
                    end
                end
                MODE_COMPARE: begin
                    if (tick) begin
                        if (at_rld) begin
                            irq_d = 1'b1;
                            out_d = ~out_q;
                        end
                        cnt_d = 16'(cnt_q + 16'h0001);
                    end
                end
                MODE_GATED: begin
                    if (gate_off) begin
                        irq_d = 1'b1;
                    end
                    if (tick && in_act) begin
                        if (at_rld) begin
                            irq_d = 1'b1;
                            cnt_d = CNT_ONE;
                            out_d = ~out_q;
                        end else begin
                            cnt_d = 16'(cnt_q + 16'h0001);
                        end
                    end
                end
                MODE_CAPCMP: begin
                    case (st_q)
                        ST_IDLE: begin
                            if (sel_edge) begin
                                st_d = ST_RUN;
                            end
                        end
                        ST_RUN: begin
                            if (sel_edge) begin
                                cap_d = cnt_q;
                                cnt_d = CNT_ONE;
                                irq_d = 1'b1;
                            end else if (tick) begin
                                if (at_rld) begin
                                    cnt_d = CNT_ONE;
                                    irq_d = 1'b1;
                                    out_d = ~out_q;
                                end else begin
                                    cnt_d = 16'(cnt_q + 16'h0001);
                                end
                            end
                        end
                        default: st_d = ST_IDLE;
                    endcase
                end
                default: begin
                    if (tick) begin
                        cnt_d = at_rld ? CNT_ONE : 16'(cnt_q + 16'h0001);
                        irq_d = at_rld;
                        out_d = at_rld ? ~out_q : out_q;
                    end
                end
            endcase
        end
        // Software byte writes land at the next edge
        if (wr && idx == ADDR_CNT_HI) begin
            cnt_d[15:8] = wbyte;
        end
        if (wr && idx == ADDR_CNT_LO) begin
            cnt_d[7:0] = wbyte;
        end
        if (wr && idx == ADDR_CAP_HI) begin
            cap_d[15:8] = wbyte;
        end
        if (wr && idx == ADDR_CAP_LO) begin
            cap_d[7:0] = wbyte;
        end
    end

    always_comb begin
        ctl_d = ctl_q;
        if (wr && idx == ADDR_CTL) begin
            ctl_d = wbyte;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= CNT_RESET;
            cap_q <= CAP_RESET;
            ctl_q <= CTL_RESET;
            st_q <= ST_IDLE;
            out_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            cap_q <= cap_d;
            ctl_q <= ctl_d;
            st_q <= st_d;
            out_q <= out_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Reload pair and count read latch
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rld_q <= RLD_RESET;
            rld_hold_q <= RLD_RESET[15:8];
            lo_hold_q <= 8'h00;
        end else begin
            if (wr && idx == ADDR_RLD_HI) begin
                rld_hold_q <= wbyte;
            end
            if (wr && idx == ADDR_RLD_LO) begin
                rld_q <= {rld_hold_q, wbyte};
            end
            if (rd && idx == ADDR_CNT_HI && run) begin
                lo_hold_q <= cnt_q[7:0];
            end
        end
    end

    wire logic [7:0] cnt_lo_rd = run ? lo_hold_q : cnt_q[7:0];
    logic [7:0] rsel;
    always_comb begin
        case (idx)
            ADDR_CNT_HI: rsel = cnt_q[15:8];
            ADDR_CNT_LO: rsel = cnt_lo_rd;
            ADDR_RLD_HI: rsel = rld_q[15:8];
            ADDR_RLD_LO: rsel = rld_q[7:0];
            ADDR_CAP_HI: rsel = cap_q[15:8];
            ADDR_CAP_LO: rsel = cap_q[7:0];
            ADDR_CTL: rsel = ctl_q;
            default: rsel = 8'h00;
        endcase
    end

    // ==========================================================
    // Bus answer and pins
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
            timer_out <= 1'b0;
            timer_out_en <= 1'b0;
        end else begin
            ack_q <= acc;
            rdat_q <= rd ? {24'h000000, rsel} : 32'h00000000;
            timer_out <= out_d;
            timer_out_en <= ctl_d[CTL_OUTEN] & ctl_d[CTL_RUN];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign timer_irq = irq_q;

    // ==========================================================
    // Checks
    // ==========================================================
    // Single-cycle events
    sequence s_capcmp_arm;
        run && mode == MODE_CAPCMP && st_q == ST_IDLE && sel_edge && !wr;
    endsequence
    sequence s_gate_leave;
        run && mode == MODE_GATED && gate_off;
    endsequence
    a_capture_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPTURE && sel_edge && !wr) |=> (cap_q == $past(cnt_q) && timer_irq))
        else $error("capture missed");
    a_capture_nclr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPTURE && tick && !wr) |=> (cnt_q == 16'($past(cnt_q) + 16'h0001)))
        else $error("capture mode count wrong");
    a_compare_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_COMPARE && tick && at_rld && !wr) |=> (timer_irq && timer_out != $past(timer_out)))
        else $error("compare event wrong");
    a_compare_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_COMPARE && tick && cnt_q == 16'hffff && !wr) |=> (cnt_q == 16'h0000))
        else $error("compare wrap wrong");
    a_gated_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == MODE_GATED && !in_act && !wr) |=> (cnt_q == $past(cnt_q)))
        else $error("gated count moved");
    a_gated_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_GATED && tick && in_act && at_rld && !wr) |=> (cnt_q == CNT_ONE && timer_irq))
        else $error("gated reload wrong");
    a_capcmp_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_capcmp_arm |=> (!timer_irq && st_q == ST_RUN))
        else $error("first edge interrupted");
    a_capcmp_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPCMP && st_q == ST_RUN && sel_edge && !wr) |=> (cnt_q == CNT_ONE && timer_irq))
        else $error("capcmp capture wrong");
    a_stopped_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!run && !wr) |=> (cnt_q == $past(cnt_q)))
        else $error("count moved while stopped");
    a_irq_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        timer_irq |-> ($past(run) && ($past(tick) || $past(sel_edge) || $past(gate_off))))
        else $error("irq without event");
    a_capture_rld: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPTURE && tick && at_rld && !wr) |=> (timer_irq && cnt_q == 16'($past(cnt_q) + 16'h0001)))
        else $error("capture reload wrong");
    a_capture_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPTURE && sel_edge && !wr) |=> (cnt_q == 16'($past(cnt_q) + {15'h0000, $past(tick)})))
        else $error("capture cleared count");
    a_compare_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_COMPARE && tick && at_rld && !wr) |=> (cnt_q == 16'($past(cnt_q) + 16'h0001)))
        else $error("compare reset count");
    a_compare_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_COMPARE && !tick && !wr) |=> (cnt_q == $past(cnt_q)))
        else $error("compare counted off tick");
    a_gated_leave: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_gate_leave |=> timer_irq)
        else $error("gate release silent");
    a_gated_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_GATED && tick && in_act && at_rld && !wr) |=> (timer_out != $past(timer_out)))
        else $error("gated output not toggled");
    a_gated_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_GATED && tick && in_act && !at_rld && !wr) |=> (cnt_q == 16'($past(cnt_q) + 16'h0001)))
        else $error("gated count step wrong");
    a_capcmp_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPCMP && st_q == ST_IDLE && !wr) |=> (cnt_q == $past(cnt_q)))
        else $error("capcmp counted before edge");
    a_capcmp_rld: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_CAPCMP && st_q == ST_RUN && !sel_edge && tick && at_rld && !wr)
        |=> (cnt_q == CNT_ONE && timer_irq))
        else $error("capcmp compare wrong");
    a_continuous_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (run && mode == MODE_OTHER && tick && at_rld && !wr) |=> (timer_out != $past(timer_out) && cnt_q == CNT_ONE))
        else $error("reload toggle wrong");
    a_stop_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!run && !wr) |=> (timer_out == $past(pol) && !timer_irq))
        else $error("stopped timer active");
    a_rld_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && idx == ADDR_RLD_HI) |=> (rld_q == $past(rld_q)))
        else $error("reload changed on high write");
    a_rld_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && idx == ADDR_RLD_LO) |=> (rld_q == {$past(rld_hold_q), $past(wbyte)}))
        else $error("reload commit wrong");
    a_count_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd && idx == ADDR_CNT_HI && run) |=> (lo_hold_q == $past(cnt_q[7:0])))
        else $error("low byte not latched");
    a_live_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd && idx == ADDR_CNT_LO && !run) |=> (wb_dat_o[7:0] == $past(cnt_q[7:0])))
        else $error("stopped low read wrong");
    a_ack_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus request not answered");
endmodule
`default_nettype wire
